// *** hdl/acf_device.sv ***
// converter control front end, device end: straps, status header, serial control port
//
// Overview of operation
// - four operating straps give one of sixteen settings
// - codes 0-B: power group, data divide 1/2/4/8
// - codes C-F: one-shot with fixed power and divide
// - modulator divide 4 fast, 8 median, 32 low
// - strap power mode sets bias and modulator divide
// - header bit 7 flags internal errors, reset needed
// - header carries unsettled, filter type, saturated flags
// - standby straps park banks of four channels
// - parked channel sends zero header and result
// - channel 0 standby disables common-mode output
// - channel 4 standby disables crystal excitation
// - mode 0: sample on rise, change on fall
// - host drives select high for serial control
// - frames are exactly sixteen bits, read or write
// - bit 15 read, 14:8 address, low byte data
// - response returns in the following frame
// - write response is zero byte then data byte
// - accesses ignored until start-up time elapses
// - host spaces frames by a minimum gap
// - control port independent of conversion clocks
// - host pulses sync after strap changes
// - illegal command answered with error word
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "acf_consts.svh"
module acf_device #(
  parameter int STARTUP_CYC = `ACF_STARTUP_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  acf_if.dev                       link,
  input  wire logic                crc_err_i,
  input  wire logic                mem_flip_i,
  input  wire logic                clk_missing_i,
  input  wire logic [7:0]          filt_unsettled_i,
  input  wire logic [7:0]          filt_saturated_i,
  input  wire logic                filter_type_i,
  input  wire logic [2:0]          chan_sel_i,
  input  wire logic [15:0]         result_i,
  output logic                     serial_mode_o,
  output acf_pkg::acf_pwr_t        power_mode_o,
  output logic      [1:0]          bias_level_o,
  output logic      [5:0]          modulator_clock_div_o,
  output logic      [1:0]          data_clock_divider_o,
  output logic                     one_shot_o,
  output logic      [7:0]          channel_standby_o,
  output logic                     common_mode_voltage_output_en_o,
  output logic                     crystal_excitation_en_o,
  output logic      [7:0]          header_o,
  output logic      [15:0]         result_o
);
  typedef struct packed {
    logic               captured;
    logic               serial;
    logic [3:0]         op_strap;
    logic [1:0]         sb_strap;
    logic               sclk_q;
    logic               cs_n_q;
    logic [4:0]         bit_cnt;
    logic [15:0]        resp;
    logic [7:0]         reg_standby;
    logic [7:0]         reg_power;
    logic [7:0]         reg_iface;
    logic [31:0]        boot_cnt;
    logic               err_sticky;
    acf_pkg::acf_cfg_t  cfg;
    logic [7:0]         standby;
    logic [7:0]         hdr;
    logic [15:0]        res;
  } acf_dev_st_t;

  localparam acf_dev_st_t ST_RST = '{
    captured:    1'b0,
    serial:      1'b0,
    op_strap:    4'h0,
    sb_strap:    2'h0,
    sclk_q:      1'b0,
    cs_n_q:      1'b1,
    bit_cnt:     5'h00,
    resp:        16'h0000,
    reg_standby: `ACF_RST_STANDBY,
    reg_power:   `ACF_RST_POWER,
    reg_iface:   `ACF_RST_IFACE,
    boot_cnt:    32'(STARTUP_CYC),
    err_sticky:  1'b0,
    cfg:         '0,
    standby:     8'h00,
    hdr:         8'h00,
    res:         16'h0000
  };

  acf_dev_st_t q_ff;
  acf_dev_st_t nxt_q;

  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic        port_on;
  logic        tx_load;
  logic        tx_shift;
  logic        rx_shift;
  logic [15:0] tx_data;
  logic [15:0] rx_data;

  // modulator divide from a power-mode code: the strap power mode, or the own divide field in serial mode
  function automatic logic [5:0] mod_of(input logic [1:0] p);
    case (p)
      2'b00:   mod_of = `ACF_MOD_LOW;
      2'b01:   mod_of = `ACF_MOD_MED;
      default: mod_of = `ACF_MOD_FAST;
    endcase
  endfunction

  // strap code to a full setting shared by every channel
  function automatic acf_pkg::acf_cfg_t strap_dec(input logic [3:0] c);
    acf_pkg::acf_cfg_t r;
    r.one_shot = c[3] & c[2];
    if (!r.one_shot) begin
      r.pwr = c[3] ? acf_pkg::ACF_PWR_FAST :
              (c[2] ? acf_pkg::ACF_PWR_MED : acf_pkg::ACF_PWR_LOW);
      r.data_clock_divider = c[1:0];
    end else begin
      case (c[1:0])
        2'b00:   r.pwr = acf_pkg::ACF_PWR_LOW;
        2'b01:   r.pwr = acf_pkg::ACF_PWR_MED;
        default: r.pwr = acf_pkg::ACF_PWR_FAST;
      endcase
      // only one-shot code E, the first of the two fast ones, slows the data clock to divide-by-2
      r.data_clock_divider = (c[1:0] == 2'b10) ? 2'h1 : 2'h0;
    end
    r.bias = r.pwr;
    r.mod_div = mod_of(r.pwr);
    strap_dec = r;
  endfunction

  // link edges seen against the previous sample; pins are synchronous to clk_i,
  // and nothing here looks at a master or data clock
  assign sclk_rise = link.sclk & ~q_ff.sclk_q;
  assign sclk_fall = ~link.sclk & q_ff.sclk_q;
  assign cs_fall   = ~link.cs_n & q_ff.cs_n_q;
  assign cs_rise   = link.cs_n & ~q_ff.cs_n_q;
  assign port_on   = q_ff.serial & (q_ff.boot_cnt == 32'h0);
  // msb is presented when the frame opens, later bits on falling edges
  assign tx_load   = port_on & cs_fall;
  assign tx_shift  = port_on & ~link.cs_n & sclk_fall;
  assign rx_shift  = port_on & ~link.cs_n & sclk_rise;

  acf_shift #(.W(`ACF_FRAME_BITS)) u_tx (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (tx_load),
    .load_val_i (q_ff.resp),
    .shift_i    (tx_shift),
    .bit_i      (1'b0),
    .data_o     (tx_data)
  );

  acf_shift #(.W(`ACF_FRAME_BITS)) u_rx (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (1'b0),
    .load_val_i (16'h0000),
    .shift_i    (rx_shift),
    .bit_i      (link.sdi),
    .data_o     (rx_data)
  );

  // next state: strap capture, frame decode, settings and header
  always_comb begin
    logic [6:0] addr;
    logic [7:0] wdat;
    nxt_q = q_ff;
    addr = rx_data[`ACF_ADDR_MSB:`ACF_ADDR_LSB];
    wdat = rx_data[7:0];
    nxt_q.sclk_q = link.sclk;
    nxt_q.cs_n_q = link.cs_n;
    if (q_ff.boot_cnt != 32'h0) begin
      nxt_q.boot_cnt = q_ff.boot_cnt - 32'h1;
    end
    // straps land once after reset and again on every sync
    if (!q_ff.captured || !link.sync_n) begin
      nxt_q.op_strap = link.operating_strap_pins;
      nxt_q.sb_strap = {link.standby_high_bank_strap, link.standby_low_bank_strap};
    end
    // interface choice is fixed at power-up, not at every sync
    if (!q_ff.captured) begin
      nxt_q.serial   = link.ctrl_select;
      nxt_q.captured = 1'b1;
    end
    if (cs_fall) begin
      nxt_q.bit_cnt = 5'h00;
    end else if (rx_shift && q_ff.bit_cnt != 5'h1F) begin
      nxt_q.bit_cnt = q_ff.bit_cnt + 5'h01;
    end
    // a frame of any other length is dropped; the old response stays queued
    if (port_on && cs_rise && q_ff.bit_cnt == 5'(`ACF_FRAME_BITS)) begin
      nxt_q.resp = `ACF_ERR_RESP;
      if (rx_data[`ACF_RW_BIT]) begin
        case (addr)
          `ACF_REG_STANDBY: nxt_q.resp = {8'h00, q_ff.reg_standby};
          `ACF_REG_POWER:   nxt_q.resp = {8'h00, q_ff.reg_power};
          `ACF_REG_IFACE:   nxt_q.resp = {8'h00, q_ff.reg_iface};
          `ACF_REG_STATUS:  nxt_q.resp = {8'h00, q_ff.err_sticky, 7'h00};
          default:          nxt_q.resp = `ACF_ERR_RESP;
        endcase
      end else begin
        nxt_q.resp = {8'h00, wdat};
        case (addr)
          `ACF_REG_STANDBY: nxt_q.reg_standby = wdat;
          `ACF_REG_POWER:   nxt_q.reg_power = wdat;
          `ACF_REG_IFACE:   nxt_q.reg_iface = wdat;
          default:          nxt_q.resp = `ACF_ERR_RESP;
        endcase
      end
    end
    // settings: serial mode gives bias and divide their own fields
    if (q_ff.serial) begin
      nxt_q.cfg.pwr = (q_ff.reg_power[1:0] == 2'b11) ? acf_pkg::ACF_PWR_FAST :
                      acf_pkg::acf_pwr_t'(q_ff.reg_power[1:0]);
      nxt_q.cfg.bias = q_ff.reg_power[3:2];
      nxt_q.cfg.mod_div = mod_of(q_ff.reg_power[5:4]);
      nxt_q.cfg.data_clock_divider = q_ff.reg_iface[1:0];
      nxt_q.cfg.one_shot = q_ff.reg_iface[2];
      nxt_q.standby = q_ff.reg_standby;
    end else begin
      nxt_q.cfg = strap_dec(q_ff.op_strap);
      nxt_q.standby = {{4{q_ff.sb_strap[1]}}, {4{q_ff.sb_strap[0]}}};
    end
    // error is sticky: only a reset clears it
    nxt_q.err_sticky = q_ff.err_sticky | crc_err_i | mem_flip_i | clk_missing_i;
    if (q_ff.standby[chan_sel_i]) begin
      nxt_q.hdr = 8'h00;
      nxt_q.res = 16'h0000;
    end else begin
      nxt_q.hdr = {5'h00, chan_sel_i};
      nxt_q.hdr[`ACF_HDR_ERR] = nxt_q.err_sticky;
      nxt_q.hdr[`ACF_HDR_UNSET] = filt_unsettled_i[chan_sel_i];
      nxt_q.hdr[`ACF_HDR_SAT] = filt_saturated_i[chan_sel_i];
      nxt_q.hdr[`ACF_HDR_FTYPE] = filter_type_i;
      nxt_q.res = result_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff <= ST_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // outputs straight from the state register
  assign link.sdo                        = tx_data[`ACF_FRAME_BITS-1];
  assign serial_mode_o                   = q_ff.serial;
  assign power_mode_o                    = q_ff.cfg.pwr;
  assign bias_level_o                    = q_ff.cfg.bias;
  assign modulator_clock_div_o           = q_ff.cfg.mod_div;
  assign data_clock_divider_o            = q_ff.cfg.data_clock_divider;
  assign one_shot_o                      = q_ff.cfg.one_shot;
  assign channel_standby_o               = q_ff.standby;
  assign common_mode_voltage_output_en_o = ~q_ff.standby[0];
  assign crystal_excitation_en_o         = ~q_ff.standby[4];
  assign header_o                        = q_ff.hdr;
  assign result_o                        = q_ff.res;
endmodule
`default_nettype wire

// *** inc/acf_consts.svh ***
// constants of the converter control front end: fields, offsets, reset values, timing
`ifndef ACF_CONSTS_SVH
`define ACF_CONSTS_SVH

// clock and timing
`define ACF_CLK_NS          10
`define ACF_STARTUP_NS      20000
`define ACF_STARTUP_CYC     ((`ACF_STARTUP_NS + `ACF_CLK_NS - 1) / `ACF_CLK_NS)
`define ACF_T30_NS          40
`define ACF_T30_CYC         ((`ACF_T30_NS + `ACF_CLK_NS - 1) / `ACF_CLK_NS)
`define ACF_SCLK_HALF_CYC   4
`define ACF_SYNC_CYC        2

// control frame layout
`define ACF_FRAME_BITS      16
`define ACF_RW_BIT          15
`define ACF_ADDR_MSB        14
`define ACF_ADDR_LSB        8
`define ACF_ERR_RESP        16'h0E00

// control port register addresses and reset values
`define ACF_REG_STANDBY     7'h00
`define ACF_REG_POWER       7'h01
`define ACF_REG_IFACE       7'h02
`define ACF_REG_STATUS      7'h03
`define ACF_RST_STANDBY     8'h00
`define ACF_RST_POWER       8'h00
`define ACF_RST_IFACE       8'h03

// modulator division values
`define ACF_MOD_FAST        6'h04
`define ACF_MOD_MED         6'h08
`define ACF_MOD_LOW         6'h20

// status header bit positions
`define ACF_HDR_ERR         7
`define ACF_HDR_UNSET       6
`define ACF_HDR_SAT         5
`define ACF_HDR_FTYPE       4

// host wishbone byte offsets
`define ACF_WB_CMD          4'h0
`define ACF_WB_RESP         4'h4
`define ACF_WB_STAT         4'h8
`define ACF_WB_PINS         4'hC

`endif

// *** inc/acf_pkg.sv ***
// types of the converter control front end: power and settings for the device end, sequencer states for the host end
package acf_pkg;

  typedef enum logic [1:0] {
    ACF_PWR_LOW  = 2'b00,
    ACF_PWR_MED  = 2'b01,
    ACF_PWR_FAST = 2'b10
  } acf_pwr_t;

  typedef struct packed {
    acf_pwr_t   pwr;
    logic [1:0] bias;
    logic [5:0] mod_div;
    logic [1:0] data_clock_divider;
    logic       one_shot;
  } acf_cfg_t;

  typedef enum logic [2:0] {
    ACF_H_IDLE = 3'b000,
    ACF_H_LOW  = 3'b001,
    ACF_H_HIGH = 3'b010,
    ACF_H_TAIL = 3'b011,
    ACF_H_GAP  = 3'b100
  } acf_hst_t;

endpackage

// *** inc/acf_if.sv ***
// link between the converter control front end and its host
`timescale 1ns/1ps
`default_nettype none
interface acf_if;
  logic       sclk;
  logic       cs_n;
  logic       sdi;
  logic       sdo;
  logic       ctrl_select;
  logic [3:0] operating_strap_pins;
  logic       standby_low_bank_strap;
  logic       standby_high_bank_strap;
  logic       sync_n;

  modport dev (
    input  sclk, cs_n, sdi, ctrl_select, operating_strap_pins,
    input  standby_low_bank_strap, standby_high_bank_strap, sync_n,
    output sdo
  );

  modport host (
    output sclk, cs_n, sdi, ctrl_select, operating_strap_pins,
    output standby_low_bank_strap, standby_high_bank_strap, sync_n,
    input  sdo
  );
endinterface
`default_nettype wire

// *** hdl/acf_shift.sv ***
// loadable shift register, msb first, used for both frame directions
`timescale 1ns/1ps
`default_nettype none
`include "acf_consts.svh"
module acf_shift #(
  parameter int W = `ACF_FRAME_BITS
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         shift_i,
  input  wire logic         bit_i,
  output logic      [W-1:0] data_o
);
  typedef struct packed {
    logic [W-1:0] sr;
  } acf_shift_st_t;

  acf_shift_st_t q_ff;
  acf_shift_st_t nxt_q;

  // load wins over shift so a new frame never starts half shifted
  always_comb begin
    nxt_q = q_ff;
    if (load_i) begin
      nxt_q.sr = load_val_i;
    end else if (shift_i) begin
      nxt_q.sr = {q_ff.sr[W-2:0], bit_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign data_o = q_ff.sr;
endmodule
`default_nettype wire

// *** hdl/acf_host.sv ***
// converter control front end, host end: wishbone slave that runs control frames
`timescale 1ns/1ps
`default_nettype none
`include "acf_consts.svh"
module acf_host #(
  parameter int STARTUP_CYC = `ACF_STARTUP_CYC,
  parameter int HALF_CYC    = `ACF_SCLK_HALF_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  acf_if.host              link
);
  typedef struct packed {
    acf_pkg::acf_hst_t st;
    logic [15:0]       cnt;
    logic [4:0]        bits;
    logic              sclk;
    logic              cs_n;
    logic [6:0]        pins;
    logic [3:0]        sync_cnt;
    logic [15:0]       resp;
    logic [31:0]       boot_cnt;
    logic              ack;
    logic [31:0]       dat;
  } acf_hst_st_t;

  acf_hst_st_t q_ff;
  acf_hst_st_t nxt_q;
  logic        req;
  logic        wr;
  logic        ready;
  logic        start;
  logic        tx_shift;
  logic        rx_shift;
  logic [15:0] tx_data;
  logic [15:0] rx_data;

  // writes act at the edge where the master sees ack
  assign req      = wb_cyc_i & wb_stb_i;
  assign wr       = req & wb_we_i & q_ff.ack;
  assign ready    = (q_ff.boot_cnt == 32'h0);
  assign start    = wr & (wb_adr_i == `ACF_WB_CMD) & (wb_sel_i[1:0] == 2'b11)
                    & ready & (q_ff.st == acf_pkg::ACF_H_IDLE);
  // next bit goes out on the falling edge, sample on the rising one
  assign tx_shift = (q_ff.st == acf_pkg::ACF_H_HIGH) & (q_ff.cnt == 16'h0)
                    & (q_ff.bits != 5'(`ACF_FRAME_BITS));
  assign rx_shift = (q_ff.st == acf_pkg::ACF_H_LOW) & (q_ff.cnt == 16'h0);

  acf_shift #(.W(`ACF_FRAME_BITS)) u_tx (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (start),
    .load_val_i (wb_dat_i[15:0]),
    .shift_i    (tx_shift),
    .bit_i      (1'b0),
    .data_o     (tx_data)
  );

  acf_shift #(.W(`ACF_FRAME_BITS)) u_rx (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (1'b0),
    .load_val_i (16'h0000),
    .shift_i    (rx_shift),
    .bit_i      (link.sdo),
    .data_o     (rx_data)
  );

  // frame sequencer and register file
  always_comb begin
    nxt_q = q_ff;
    nxt_q.ack = req & ~q_ff.ack;
    if (q_ff.boot_cnt != 32'h0) begin
      nxt_q.boot_cnt = q_ff.boot_cnt - 32'h1;
    end
    if (q_ff.cnt != 16'h0) begin
      nxt_q.cnt = q_ff.cnt - 16'h1;
    end
    case (wb_adr_i)
      `ACF_WB_RESP: nxt_q.dat = {16'h0000, q_ff.resp};
      `ACF_WB_STAT: nxt_q.dat = {30'h0, ready, q_ff.st != acf_pkg::ACF_H_IDLE};
      `ACF_WB_PINS: nxt_q.dat = {25'h0, q_ff.pins};
      default:      nxt_q.dat = 32'h0;
    endcase
    if (wr && wb_adr_i == `ACF_WB_PINS && wb_sel_i[0]) begin
      nxt_q.pins = wb_dat_i[6:0];
      if (wb_dat_i[7]) begin
        nxt_q.sync_cnt = 4'(`ACF_SYNC_CYC);
      end
    end else if (q_ff.sync_cnt != 4'h0) begin
      nxt_q.sync_cnt = q_ff.sync_cnt - 4'h1;
    end
    case (q_ff.st)
      acf_pkg::ACF_H_IDLE: begin
        if (start) begin
          nxt_q.cs_n = 1'b0;
          nxt_q.bits = 5'h00;
          nxt_q.cnt  = 16'(HALF_CYC - 1);
          nxt_q.st   = acf_pkg::ACF_H_LOW;
        end
      end
      acf_pkg::ACF_H_LOW: begin
        if (q_ff.cnt == 16'h0) begin
          nxt_q.sclk = 1'b1;
          nxt_q.bits = q_ff.bits + 5'h01;
          nxt_q.cnt  = 16'(HALF_CYC - 1);
          nxt_q.st   = acf_pkg::ACF_H_HIGH;
        end
      end
      acf_pkg::ACF_H_HIGH: begin
        if (q_ff.cnt == 16'h0) begin
          nxt_q.sclk = 1'b0;
          nxt_q.cnt  = 16'(HALF_CYC - 1);
          nxt_q.st   = (q_ff.bits == 5'(`ACF_FRAME_BITS)) ?
                       acf_pkg::ACF_H_TAIL : acf_pkg::ACF_H_LOW;
        end
      end
      acf_pkg::ACF_H_TAIL: begin
        if (q_ff.cnt == 16'h0) begin
          nxt_q.cs_n = 1'b1;
          nxt_q.resp = rx_data;
          nxt_q.cnt  = 16'(`ACF_T30_CYC - 1);
          nxt_q.st   = acf_pkg::ACF_H_GAP;
        end
      end
      acf_pkg::ACF_H_GAP: begin
        // enforced quiet time before the next frame
        if (q_ff.cnt == 16'h0) begin
          nxt_q.st = acf_pkg::ACF_H_IDLE;
        end
      end
      default: nxt_q.st = acf_pkg::ACF_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff <= '{st: acf_pkg::ACF_H_IDLE, cnt: 16'h0, bits: 5'h00, sclk: 1'b0,
                cs_n: 1'b1, pins: 7'h00, sync_cnt: 4'h0, resp: 16'h0000,
                boot_cnt: 32'(STARTUP_CYC), ack: 1'b0, dat: 32'h0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign wb_ack_o                     = q_ff.ack;
  assign wb_dat_o                     = q_ff.dat;
  assign link.sclk                    = q_ff.sclk;
  assign link.cs_n                    = q_ff.cs_n;
  assign link.sdi                     = tx_data[`ACF_FRAME_BITS-1];
  assign link.operating_strap_pins    = q_ff.pins[3:0];
  assign link.standby_low_bank_strap  = q_ff.pins[4];
  assign link.standby_high_bank_strap = q_ff.pins[5];
  assign link.ctrl_select             = q_ff.pins[6];
  assign link.sync_n                  = (q_ff.sync_cnt == 4'h0);
endmodule
`default_nettype wire

// *** test/acf_assertions.sv ***
// link checker between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module acf_assertions #(
  parameter int STARTUP_CYC = 20
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdi,
  input  wire logic sdo
);
  logic [4:0]  bits_ff;
  logic [15:0] up_ff;

  // rises per frame; cycles since reset, saturating so it never wraps
  always_ff @(posedge clk_i) begin
    if (rst_i || $fell(cs_n)) bits_ff <= 5'h00;
    else if ($rose(sclk)) bits_ff <= bits_ff + 5'h01;
    if (rst_i) up_ff <= 16'h0000;
    else if (up_ff != 16'hFFFF) up_ff <= up_ff + 16'h0001;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_SCLK_IDLE: assert property (cs_n |-> !sclk) else $error("sclk off idle");
  AST_SDI_HOLD: assert property (sclk && $past(sclk) |-> $stable(sdi)) else $error("sdi moved");
  AST_SDO_HOLD: assert property (sclk && $past(sclk) |-> $stable(sdo)) else $error("sdo moved");
  AST_HALF: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk) else $error("sclk high width");
  AST_MSB_LEAD: assert property ($fell(cs_n) |-> !sclk[*2]) else $error("no msb lead");
  AST_SIXTEEN: assert property ($rose(cs_n) |-> bits_ff == 5'h10) else $error("frame length");
  AST_GAP: assert property ($rose(cs_n) |-> cs_n[*4]) else $error("frame gap short");
  AST_START: assert property (!cs_n |-> up_ff >= STARTUP_CYC) else $error("frame too early");
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// bench: host end and device end joined over the link
`timescale 1ns/1ps
`default_nettype none
`include "acf_consts.svh"
module tb_top;
  logic        clk = 1'h0;
  logic        rst_h = 1'h1;
  logic        rst_d = 1'h1;
  logic        cyc = 1'h0;
  logic        stb = 1'h0;
  logic        we = 1'h0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [2:0]  err = 3'h0;
  logic [3:0]  sel = 4'hF;
  logic [7:0]  flt = 8'h00;
  logic        ftype = 1'h0;
  logic [2:0]  csel = 3'h0;
  logic [15:0] res = 16'h0000;
  logic [1:0]  pwr;
  logic [1:0]  bias;
  logic        smode;
  logic [5:0]  mdiv;
  logic [1:0]  ddiv;
  logic        osh;
  logic [7:0]  stby;
  logic        cm_en;
  logic        xt_en;
  logic [7:0]  hdr;
  logic [15:0] rout;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          ticks = 0;

  acf_if lnk ();
  acf_host #(.STARTUP_CYC(20)) i_acf_host (.clk_i(clk), .rst_i(rst_h), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .link(lnk));
  acf_device #(.STARTUP_CYC(20)) i_acf_device (.clk_i(clk), .rst_i(rst_d), .link(lnk),
    .crc_err_i(err[0]), .mem_flip_i(err[1]), .clk_missing_i(err[2]), .filt_unsettled_i(flt),
    .filt_saturated_i(flt), .filter_type_i(ftype), .chan_sel_i(csel), .result_i(res),
    .serial_mode_o(smode), .power_mode_o(pwr), .bias_level_o(bias),
    .modulator_clock_div_o(mdiv),
    .data_clock_divider_o(ddiv), .one_shot_o(osh), .channel_standby_o(stby),
    .common_mode_voltage_output_en_o(cm_en), .crystal_excitation_en_o(xt_en),
    .header_o(hdr), .result_o(rout));
  acf_assertions #(.STARTUP_CYC(20)) i_acf_assertions (.clk_i(clk), .rst_i(rst_h),
    .sclk(lnk.sclk), .cs_n(lnk.cs_n), .sdi(lnk.sdi), .sdo(lnk.sdo));

  always #5 clk = ~clk;

  // cycle ceiling: a hang counts as a mismatch
  always @(posedge clk) begin
    ticks++;
    if (ticks == 30000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // classic cycle; request held until the rising edge that samples ack high,
  // read data taken at that same edge, then one idle cycle before the next
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wait_idle();
    logic [31:0] s = 32'h0;
    while (s[1:0] !== 2'h2) wb(1'h0, `ACF_WB_STAT, 32'h0, s);
  endtask

  // straps written with the sync bit set, then time to resample and decode
  task automatic pins(input logic [6:0] v);
    logic [31:0] q;
    wb(1'h1, `ACF_WB_PINS, {24'h0, 1'h1, v}, q);
    repeat (8) @(posedge clk);
  endtask

  task automatic frame(input logic [15:0] c, input logic [15:0] e);
    logic [31:0] q;
    wait_idle();
    wb(1'h1, `ACF_WB_CMD, {16'h0, c}, q);
    wait_idle();
    wb(1'h0, `ACF_WB_RESP, 32'h0, q);
    chk(q, {16'h0, e});
  endtask

  task automatic strap_modes();
    logic [1:0] p;
    logic [1:0] dv;
    logic [5:0] m;
    for (int c = 0; c < 16; c++) begin
      p = (c < 12) ? c[3:2] : (c < 14) ? c[1:0] : 2'h2;
      dv = (c < 12) ? c[1:0] : (c == 14) ? 2'h1 : 2'h0;
      m = (p == 2'h2) ? 6'h04 : (p == 2'h1) ? 6'h08 : 6'h20;
      pins({3'h0, c[3:0]});
      chk({smode, pwr, bias, mdiv, ddiv, osh}, {1'h0, p, p, m, dv, c >= 12});
    end
  endtask

  // high-bank channel formatted while each standby pair is applied
  task automatic standby_banks();
    logic [1:0] k;
    csel <= 3'h4;
    res <= 16'hBEEF;
    flt <= 8'h10;
    ftype <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      pins({1'h0, k[1], k[0], 4'h0});
      chk({stby, cm_en, xt_en}, {{4{k[1]}}, {4{k[0]}}, ~k[0], ~k[1]});
      chk({hdr, rout}, k[1] ? 24'h0 : 24'h74BEEF);
    end
    err <= 3'h1;
    @(posedge clk);
    err <= 3'h0;
    pins(7'h00);
    chk({hdr, rout}, 24'hF4BEEF);
  endtask

  // each error source alone sets the sticky header bit; only a device reset clears it
  task automatic err_bits();
    for (int i = 0; i < 3; i++) begin
      rst_d <= 1'h1;
      @(posedge clk);
      rst_d <= 1'h0;
      repeat (4) @(posedge clk);
      chk(hdr, 8'h74);
      err <= 3'h1 << i;
      @(posedge clk);
      err <= 3'h0;
      repeat (2) @(posedge clk);
      chk(hdr, 8'hF4);
    end
  endtask

  // device restarted with serial select high, then a chain of commands
  task automatic serial_cmds();
    logic [31:0] q;
    pins(7'h40);
    rst_d <= 1'h1;
    repeat (2) @(posedge clk);
    rst_d <= 1'h0;
    repeat (30) @(posedge clk);
    frame(16'h0103, 16'h0000);
    chk({smode, pwr, bias, mdiv}, {1'h1, 2'h2, 2'h0, 6'h20});
    frame(16'h8100, 16'h0003);
    frame(16'h0380, 16'h0003);
    frame(16'hFF00, 16'h0E00);
    frame(16'h8200, 16'h0E00);
    frame(16'h0000, 16'h0003);
    // command write without both low byte lanes is acked but never sent
    sel <= 4'hC;
    wb(1'h1, `ACF_WB_CMD, 32'h0155, q);
    sel <= 4'hF;
    frame(16'h8100, 16'h0000);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_h <= 1'h0;
    rst_d <= 1'h0;
    @(posedge clk);
    strap_modes();
    standby_banks();
    err_bits();
    serial_cmds();
    wrap_up();
  end
endmodule
`default_nettype wire
